// *** pkg/scc_pkg.sv ***
`default_nettype none
package scc_pkg;

  // Register offsets (byte addresses on the management bus)
  localparam logic [7:0] OFF_BUS_IDENTITY = 8'h00;
  localparam logic [7:0] OFF_SOFT_RESET = 8'h01;
  localparam logic [7:0] OFF_GENERAL_CFG = 8'h02;

  // Identity register fields
  localparam int IDENT_ADDR_LSB = 1;
  localparam int IDENT_OVR_BIT = 0;
  localparam logic IDENT_OVR_RST = 1'h0;

  // Soft reset control fields
  localparam int SRST_RELOAD_BIT = 2;
  localparam int SRST_FULL_BIT = 1;
  localparam int SRST_LOGIC_BIT = 0;

  // General configuration fields and reset values
  localparam int GCFG_CONT_BIT = 6;
  localparam int GCFG_LANE_LSB = 4;
  localparam int GCFG_CRC_BIT = 1;
  localparam int GCFG_VOLT_BIT = 0;
  localparam logic GCFG_CONT_RST = 1'h0;
  localparam logic [1:0] GCFG_LANE_RST = 2'h3;
  localparam logic GCFG_CRC_RST = 1'h1;

  // Lane count encodings
  localparam logic [1:0] LANES_ONE = 2'h0;
  localparam logic [1:0] LANES_TWO = 2'h1;
  localparam logic [1:0] LANES_FOUR = 2'h3;

  // Length of the internal soft reset pulse in clock cycles
  localparam int SRST_PULSE_CYC = 4;
  // Enabled cycles spent waiting for straps to clear the synchroniser
  localparam int STRAP_WAIT_CYC = 6;

  // Startup sequencer states
  typedef enum logic [2:0] {
    ST_STRAP = 3'b001,
    ST_RUN = 3'b010,
    ST_HOLD = 3'b100
  } scc_state_t;

  // Register write/read request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } scc_req_t;

  // Configuration carried to the core
  typedef struct packed {
    logic cont_clk;
    logic [1:0] lanes;
    logic crc_en;
    logic volt_1v8;
    logic [6:0] slave_addr;
  } scc_cfg_t;

endpackage
`default_nettype wire

// *** logic/scc_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
// Three-stage synchroniser; output changes once stages two and three agree
module scc_sync #(
  parameter int W = 1
) (
  input wire logic ref_clk_i, // Clock
  input wire logic nrst_i, // Sync reset, active low
  input wire logic en_i, // Clock enable
  input wire logic [W-1:0] d_i, // Asynchronous input
  output logic [W-1:0] q_o // Filtered output
);
  logic [W-1:0] s1_ff, s2_ff, s3_ff, q_ff;
  logic [W-1:0] nxt_q;

  // Accept a new value only when the last two stages agree
  always_comb
  begin
    nxt_q = q_ff;
    if (s2_ff == s3_ff)
    begin
      nxt_q = s3_ff;
    end
  end

  // Register the chain; first stage feeds only the second
  always_ff @(posedge ref_clk_i)
  begin
    if (!nrst_i)
    begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
      q_ff <= '0;
    end
    else if (en_i)
    begin
      s1_ff <= d_i;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      q_ff <= nxt_q;
    end
  end

  assign q_o = q_ff;
endmodule
`default_nettype wire

// *** logic/scc_regs.sv ***
`timescale 1ns/1ps
`default_nettype none
module scc_regs (
  input wire logic ref_clk_i, // 25 MHz clock
  input wire logic nrst_i, // Sync reset, active low
  input wire logic clk_en_i, // Clock enable, freezes state
  input wire logic [6:0] strap_addr_i, // Strapped slave address pins
  input wire logic identity_strap_pin_i, // Bus voltage strap pin
  input wire logic reg_wr_i, // Register write strobe
  input wire logic reg_rd_i, // Register read strobe
  input wire logic [7:0] reg_addr_i, // Register offset
  input wire logic [7:0] reg_wdata_i, // Write data
  output logic [7:0] reg_rdata_o, // Read data, registered
  output logic reg_rvalid_o, // Read data valid pulse
  output logic [6:0] slave_addr_o, // Active slave address
  output logic cont_clk_o, // Continuous clock lane
  output logic [1:0] lanes_o, // Data lane select
  output logic crc_en_o, // TX CRC generator enable
  output logic volt_1v8_o, // Bus level, 1 = 1.8 V
  output logic rom_reload_o, // ROM reload pulse
  output logic logic_rst_o // Digital logic reset pulse
);

  ////////////////////////////////////////////////////////////////////////////
  // Strap synchronisation

  logic [7:0] strap_sync;
  scc_sync #(.W(8)) u_sync (
    .ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .en_i(clk_en_i),
    .d_i({identity_strap_pin_i, strap_addr_i}),
    .q_o(strap_sync)
  );

  ////////////////////////////////////////////////////////////////////////////
  // State

  scc_pkg::scc_req_t req; // Bundled request
  scc_pkg::scc_cfg_t cfg_ff, nxt_cfg; // Configuration registers
  scc_pkg::scc_state_t st_ff, nxt_st; // Startup sequencer
  logic ovr_ff, nxt_ovr; // Identity override bit
  logic [6:0] prog_addr_ff, nxt_prog_addr; // Programmed address
  logic [2:0] cnt_ff, nxt_cnt; // Strap settle / pulse counter
  logic reload_ff, nxt_reload; // Reload pulse
  logic lrst_ff, nxt_lrst; // Logic reset pulse
  logic [7:0] rdata_ff, nxt_rdata; // Read data
  logic rvalid_ff, nxt_rvalid; // Read valid
  logic wr_id, wr_rst, wr_cfg; // Decoded writes
  logic full_rst; // Internal full reset

  assign req = '{wr: reg_wr_i, rd: reg_rd_i, addr: reg_addr_i, wdata: reg_wdata_i};
  assign wr_id = req.wr && (req.addr == scc_pkg::OFF_BUS_IDENTITY);
  assign wr_rst = req.wr && (req.addr == scc_pkg::OFF_SOFT_RESET);
  assign wr_cfg = req.wr && (req.addr == scc_pkg::OFF_GENERAL_CFG) && (st_ff == scc_pkg::ST_RUN);
  // Full soft reset takes effect on the next edge, like the pin
  assign full_rst = wr_rst && req.wdata[scc_pkg::SRST_FULL_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic

  // Sequencer, registers and pulses
  always_comb
  begin
    nxt_st = st_ff;
    nxt_cfg = cfg_ff;
    nxt_ovr = ovr_ff;
    nxt_prog_addr = prog_addr_ff;
    nxt_cnt = cnt_ff;
    nxt_reload = 1'b0;
    nxt_lrst = 1'b0;
    nxt_rvalid = req.rd;
    nxt_rdata = rdata_ff;
    case (st_ff)
      scc_pkg::ST_STRAP:
      begin
        // Wait for straps to pass the synchroniser, then latch them
        nxt_cnt = cnt_ff + 3'h1;
        if (cnt_ff == 3'(scc_pkg::STRAP_WAIT_CYC - 1))
        begin
          nxt_cfg.volt_1v8 = strap_sync[7];
          nxt_prog_addr = strap_sync[6:0];
          nxt_cnt = 3'h0;
          nxt_st = scc_pkg::ST_RUN;
        end
      end
      scc_pkg::ST_RUN:
      begin
        if (wr_rst && req.wdata[scc_pkg::SRST_LOGIC_BIT])
        begin
          nxt_st = scc_pkg::ST_HOLD;
          nxt_cnt = 3'h0;
        end
        if (wr_rst && req.wdata[scc_pkg::SRST_RELOAD_BIT])
        begin
          nxt_reload = 1'b1;
        end
      end
      scc_pkg::ST_HOLD:
      begin
        // Hold logic reset for a few cycles, registers untouched
        nxt_lrst = 1'b1;
        nxt_cnt = cnt_ff + 3'h1;
        if (cnt_ff == 3'(scc_pkg::SRST_PULSE_CYC - 1))
        begin
          // Last cycle of HOLD; the registered pulse stays high through the first cycle back in RUN
          nxt_cnt = 3'h0;
          nxt_st = scc_pkg::ST_RUN;
        end
      end
      default:
      begin
        nxt_st = scc_pkg::ST_STRAP;
      end
    endcase
    // Identity writes; address field writable only under override
    if (wr_id)
    begin
      nxt_ovr = req.wdata[scc_pkg::IDENT_OVR_BIT];
      if (ovr_ff)
      begin
        nxt_prog_addr = req.wdata[7:scc_pkg::IDENT_ADDR_LSB];
      end
    end
    // General configuration; reserved bits 7,3:2 dropped
    if (wr_cfg)
    begin
      nxt_cfg.cont_clk = req.wdata[scc_pkg::GCFG_CONT_BIT];
      nxt_cfg.lanes = req.wdata[scc_pkg::GCFG_LANE_LSB +: 2];
      nxt_cfg.crc_en = req.wdata[scc_pkg::GCFG_CRC_BIT];
      nxt_cfg.volt_1v8 = req.wdata[scc_pkg::GCFG_VOLT_BIT];
    end
    // Active address: strap unless override set
    nxt_cfg.slave_addr = nxt_ovr ? nxt_prog_addr : strap_sync[6:0];
    if (!nxt_ovr)
    begin
      nxt_prog_addr = strap_sync[6:0];
    end
    // Read mux; self-clearing bits always read zero
    if (req.rd)
    begin
      case (req.addr)
        scc_pkg::OFF_BUS_IDENTITY: nxt_rdata = {cfg_ff.slave_addr, ovr_ff};
        scc_pkg::OFF_SOFT_RESET: nxt_rdata = 8'h00;
        scc_pkg::OFF_GENERAL_CFG: nxt_rdata = {1'b0, cfg_ff.cont_clk, cfg_ff.lanes,
                                               2'b00, cfg_ff.crc_en, cfg_ff.volt_1v8};
        default: nxt_rdata = 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  // Pin reset or full soft reset restore every register in this block and restart straps; the synchroniser is reset by the pin only
  always_ff @(posedge ref_clk_i)
  begin
    if (!nrst_i || (clk_en_i && full_rst))
    begin
      st_ff <= scc_pkg::ST_STRAP;
      cfg_ff <= '{cont_clk: scc_pkg::GCFG_CONT_RST, lanes: scc_pkg::GCFG_LANE_RST,
                  crc_en: scc_pkg::GCFG_CRC_RST, volt_1v8: 1'b0, slave_addr: 7'h00};
      ovr_ff <= scc_pkg::IDENT_OVR_RST;
      prog_addr_ff <= 7'h00;
      cnt_ff <= 3'h0;
      reload_ff <= 1'b0;
      lrst_ff <= 1'b0;
      rdata_ff <= 8'h00;
      rvalid_ff <= 1'b0;
    end
    else if (clk_en_i)
    begin
      st_ff <= nxt_st;
      cfg_ff <= nxt_cfg;
      ovr_ff <= nxt_ovr;
      prog_addr_ff <= nxt_prog_addr;
      cnt_ff <= nxt_cnt;
      reload_ff <= nxt_reload;
      lrst_ff <= nxt_lrst;
      rdata_ff <= nxt_rdata;
      rvalid_ff <= nxt_rvalid;
    end
  end

  assign reg_rdata_o = rdata_ff;
  assign reg_rvalid_o = rvalid_ff;
  assign slave_addr_o = cfg_ff.slave_addr;
  assign cont_clk_o = cfg_ff.cont_clk;
  assign lanes_o = cfg_ff.lanes;
  assign crc_en_o = cfg_ff.crc_en;
  assign volt_1v8_o = cfg_ff.volt_1v8;
  assign rom_reload_o = reload_ff;
  assign logic_rst_o = lrst_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  a_reload_pulse: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    clk_en_i && wr_rst && req.wdata[2] && st_ff == scc_pkg::ST_RUN && !full_rst
    |=> rom_reload_o ##1 (!rom_reload_o || !clk_en_i))
    else $error("reload pulse wrong");
  a_full_reset: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    clk_en_i && full_rst |=> lanes_o == 2'h3 && crc_en_o && !cont_clk_o && !ovr_ff)
    else $error("full reset did not restore");
  a_logic_rst_keep: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    logic_rst_o && clk_en_i && !req.wr |=> $stable(cfg_ff))
    else $error("logic reset changed registers");
  a_logic_rst_len: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    $rose(logic_rst_o) && clk_en_i |-> ##[1:8] !logic_rst_o)
    else $error("logic reset too long");
  a_addr_strap: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    !ovr_ff && $past(!ovr_ff) && clk_en_i && $past(clk_en_i) && st_ff == scc_pkg::ST_RUN
    |-> slave_addr_o == $past(strap_sync[6:0]))
    else $error("address not strapped");
  a_addr_ovr: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    clk_en_i && wr_id && ovr_ff && req.wdata[0] && !full_rst
    |=> slave_addr_o == $past(req.wdata[7:1]))
    else $error("override address not taken");
  a_cfg_write: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    clk_en_i && wr_cfg |=> lanes_o == $past(req.wdata[5:4]) && cont_clk_o == $past(req.wdata[6]))
    else $error("config write lost");
  a_crc_write: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    clk_en_i && wr_cfg |=> crc_en_o == $past(req.wdata[1]) && volt_1v8_o == $past(req.wdata[0]))
    else $error("crc or voltage write lost");
  a_rsvd_zero: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    clk_en_i && req.rd && req.addr == scc_pkg::OFF_GENERAL_CFG && !full_rst
    |=> reg_rdata_o[7] == 1'b0 && reg_rdata_o[3:2] == 2'b00)
    else $error("reserved bits nonzero");
  c_reload: cover property (@(posedge ref_clk_i) rom_reload_o);
  c_lrst: cover property (@(posedge ref_clk_i) $fell(logic_rst_o));
  c_ovr: cover property (@(posedge ref_clk_i) ovr_ff && slave_addr_o != strap_sync[6:0]);
endmodule
`default_nettype wire

// *** test/scc_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// Register bus master, standing for the local or the remote controller
module scc_host_model (
  input wire logic ref_clk_i, // Bus clock
  input wire logic [7:0] rdata_i, // Read data from the block
  input wire logic rvalid_i, // Read data valid
  output logic wr_o, // Write strobe
  output logic rd_o, // Read strobe
  output logic [7:0] addr_o, // Register offset
  output logic [7:0] wdata_o // Write data
);
  // Idle bus at time zero
  initial
  begin
    wr_o = 1'b0;
    rd_o = 1'b0;
    addr_o = 8'h00;
    wdata_o = 8'h00;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // One-cycle write; voltage bit writes here stand for remote accesses
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    wr_o <= 1'b1;
    addr_o <= a;
    wdata_o <= d;
    @(posedge ref_clk_i);
    wr_o <= 1'b0;
    addr_o <= ~a; // Released lines must not keep the old value
    wdata_o <= ~d;
  endtask
  // Read with a bounded wait, so a slow answer is tolerated
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    int n;
    @(posedge ref_clk_i);
    rd_o <= 1'b1;
    addr_o <= a;
    @(posedge ref_clk_i);
    rd_o <= 1'b0;
    addr_o <= ~a;
    #1;
    n = 0;
    while (rvalid_i !== 1'b1 && n < 4)
    begin
      @(posedge ref_clk_i);
      #1;
      n++;
    end
    d = (rvalid_i === 1'b1) ? rdata_i : 8'hXX; // No answer gives a sure mismatch
  endtask
endmodule
`default_nettype wire

// *** test/test_serializer_core_config_regs.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_serializer_core_config_regs;
  localparam logic [6:0] STRAP_A = 7'h2A; // Strapped address used throughout
  logic ref_clk_i, nrst_i, strap_v, wr, rd, rvalid, cont, crc, volt, reload, lrst;
  logic clk_en; // Clock enable driven by the bench
  logic [6:0] strap_a, slv;
  logic [7:0] addr, wdata, rdata, rv;
  logic [1:0] lanes;
  int err_count = 0;
  int n_compared = 0;
  int cyc = 0;
  int n;
  scc_regs dut (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .clk_en_i(clk_en),
    .strap_addr_i(strap_a), .identity_strap_pin_i(strap_v), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid),
    .slave_addr_o(slv), .cont_clk_o(cont), .lanes_o(lanes), .crc_en_o(crc),
    .volt_1v8_o(volt), .rom_reload_o(reload), .logic_rst_o(lrst));
  scc_host_model host (.ref_clk_i(ref_clk_i), .rdata_i(rdata), .rvalid_i(rvalid),
    .wr_o(wr), .rd_o(rd), .addr_o(addr), .wdata_o(wdata));
  ////////////////////////////////////////////////////////////////////////////////
  // 25 MHz clock
  initial
  begin
    ref_clk_i = 1'b0;
    forever #20 ref_clk_i = ~ref_clk_i;
  end
  // Hang guard, well above the roughly 110 cycles the run needs
  always @(posedge ref_clk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 4000)
    begin
      err_count++;
      end_sim();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("Mismatches %0d of %0d compares", err_count, n_compared);
    if (err_count == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    n_compared++;
    if (got !== exp)
    begin
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, msg, got, exp);
      err_count++;
    end
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    host.rd_reg(a, rv);
    chk(rv, exp, "register read");
  endtask
  // Count samples with the chosen pulse high over eight cycles
  task automatic count_pulse(input bit sel);
    n = 0;
    repeat (8)
    begin
      #1;
      n += sel ? int'(lrst) : int'(reload);
      @(posedge ref_clk_i);
    end
  endtask
  // Packed view of the configuration outputs
  function automatic logic [7:0] cfg_out();
    return {3'h0, cont, lanes, crc, volt};
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  // Values after start-up, strap capture, unmapped space
  task automatic t_reset();
    rd_chk(8'h02, 8'h33);
    chk(cfg_out(), 8'h0F, "config outputs");
    rd_chk(8'h00, {STRAP_A, 1'b0});
    chk({1'b0, slv}, {1'b0, STRAP_A}, "strap address");
    rd_chk(8'h01, 8'h00);
    rd_chk(8'h7E, 8'h00);
  endtask
  // Every lane code, both clock modes, CRC and voltage, reserved bits set
  task automatic t_gcfg();
    logic [1:0] ln [3] = '{scc_pkg::LANES_ONE, scc_pkg::LANES_TWO, scc_pkg::LANES_FOUR};
    logic [7:0] d;
    for (int i = 0; i < 3; i++)
    begin
      d = {1'b1, i[0], ln[i], 2'h3, ~i[0], ~i[0]};
      host.wr_reg(8'h02, d);
      rd_chk(8'h02, d & 8'h73);
      chk(cfg_out(), {3'h0, i[0], ln[i], ~i[0], ~i[0]}, "config out");
    end
  endtask
  // Address writes refused, then taken under override, then strap again
  task automatic t_ident();
    host.wr_reg(8'h00, 8'h22);
    rd_chk(8'h00, {STRAP_A, 1'b0});
    host.wr_reg(8'h00, 8'h01);
    host.wr_reg(8'h00, 8'h23);
    rd_chk(8'h00, 8'h23);
    chk({1'b0, slv}, 8'h11, "override address");
    host.wr_reg(8'h00, 8'h44);
    repeat (3) @(posedge ref_clk_i);
    rd_chk(8'h00, {STRAP_A, 1'b0});
    chk({1'b0, slv}, {1'b0, STRAP_A}, "address back to strap");
  endtask
  // ROM reload: one pulse, bit self-clears
  task automatic t_reload();
    host.wr_reg(8'h01, 8'h04);
    count_pulse(1'b0);
    chk(8'(n), 8'h01, "reload pulse");
    rd_chk(8'h01, 8'h00);
  endtask
  // Logic reset keeps register contents
  task automatic t_lrst();
    host.wr_reg(8'h02, 8'h41);
    host.wr_reg(8'h01, 8'h01);
    count_pulse(1'b1);
    chk(8'(n), 8'(scc_pkg::SRST_PULSE_CYC), "logic reset length");
    rd_chk(8'h02, 8'h41);
    rd_chk(8'h01, 8'h00);
  endtask
  // Full reset clears registers and reloads straps
  task automatic t_full();
    host.wr_reg(8'h00, 8'h01);
    host.wr_reg(8'h00, 8'h67);
    strap_v <= 1'b0;
    host.wr_reg(8'h01, 8'h02);
    repeat (12) @(posedge ref_clk_i);
    rd_chk(8'h02, 8'h32);
    rd_chk(8'h00, {STRAP_A, 1'b0});
    chk(cfg_out(), 8'h0E, "config after full reset");
  endtask
  // Clock enable low: writes and reload requests are frozen out
  task automatic t_clken();
    @(posedge ref_clk_i);
    clk_en <= 1'b0;
    host.wr_reg(8'h02, 8'h40);
    host.wr_reg(8'h01, 8'h04);
    #1;
    chk({7'h00, reload}, 8'h00, "reload while frozen");
    chk(cfg_out(), 8'h0E, "config while frozen");
    @(posedge ref_clk_i);
    clk_en <= 1'b1;
    rd_chk(8'h02, 8'h32);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    nrst_i <= 1'b0;
    clk_en <= 1'b1;
    strap_a <= STRAP_A;
    strap_v <= 1'b1;
    repeat (5) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    repeat (10) @(posedge ref_clk_i);
    t_reset();
    t_gcfg();
    t_ident();
    t_reload();
    t_lrst();
    t_full();
    t_clken();
    end_sim();
  end
endmodule
`default_nettype wire
